// ---- hdl/acs_clk_sel.sv ----
// sample clock selector: internal synthesizer, input scan, status, irq
// assumes reg_* comes from same-clock logic and ref_pin from outside
// Behaviour
// [RQ1] master rate trimmed in 1 Hz steps, within 5%
// [RQ2] presets for 0.1% and 4% pull up/down
// [RQ3] coarse 50 Hz steps, fine steps, trim reset
// [RQ4] trim applies only in master, this card only
// [RQ5] auto mode follows a valid external input
// [RQ6] lost reference falls back to internal master
// [RQ7] preferred input first, then others in turn
// [RQ8] no valid input selects internal master clock
// [RQ9] internal mode ignores all external inputs
// [RQ10] each input reports none, lock or sync
// [RQ11] slaved rate kept, differing host rate refused
// [RQ12] flag detected rate differing from requested rate
// [RQ13] quad rate carries sixteen channels per port
// [RQ14] double rate halves the port channel count
// [RQ15] sync needs matching rate and phase
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module acs_clk_sel (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [3:0]        ref_pin,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   irq,
    output logic                   sample_tick,
    output logic                   clk_master,
    output var acs_pkg::acs_src_t  cur_source,
    output logic      [6:0]        madi_chans
);
    import acs_pkg::*;
    localparam int NIN = `ACS_N_IN;

    logic               mode_int_ff, nxt_mode_int;
    logic [1:0]         pref_ff, nxt_pref;
    logic               m56_ff, nxt_m56;
    logic [17:0]        rate_req_ff, nxt_rate_req;
    logic signed [18:0] trim_ff, nxt_trim;
    acs_src_t           src_ff, nxt_src;
    logic [2*NIN-1:0]   lock_ff, lock_vec;
    logic               err_ff, nxt_err;
    logic [6:0]         chans_ff, nxt_chans;
    logic [3:0]         stat_ff, nxt_stat, mask_ff, nxt_mask;
    logic [31:0]        rdata_ff, nxt_rdata;

    logic [NIN-1:0]     in_valid, in_edge, in_phase;
    logic [15:0]        in_per [NIN];
    logic [1:0]         sel_idx, scan_idx;
    logic [15:0]        sel_per;
    logic               dev_tick, synth_tick, found, refused, err_now;
    logic [17:0]        synth_rate, lim;
    logic signed [19:0] t;
    logic [3:0]         ev;

    // product test avoids a divider: rate * period must be near clk_hz
    function automatic logic rate_match(input logic [17:0] rate,
                                        input logic [15:0] per);
        logic [33:0] prod;
        logic [33:0] tol;
        prod = 34'(rate) * 34'(per);
        tol  = 34'(rate) * `ACS_MATCH_MUL;
        return (prod + tol >= `ACS_CLK_HZ) && (prod <= `ACS_CLK_HZ + tol);
    endfunction

    acs_mon_if mif [NIN] ();

    assign clk_master = (src_ff == ACS_SRC_INT);
    assign sel_idx    = src_ff[1:0];
    assign sel_per    = clk_master ? 16'h0000 : in_per[sel_idx];
    assign dev_tick   = clk_master ? synth_tick : in_edge[sel_idx];
    // trim touches only this card's own synthesizer, and only as master
    assign synth_rate = clk_master ? 18'(rate_req_ff + trim_ff)
                                   : rate_req_ff;                  // [RQ4]

    acs_rate_synth u_synth (
        .clk  (clk),
        .rst  (rst),
        .rate (synth_rate),
        .tick (synth_tick)
    );

    for (genvar g = 0; g < NIN; g++)
    begin : g_in
        logic [15:0] d;
        logic        freq_ok;
        acs_input_mon u_mon (
            .clk     (clk),
            .rst     (rst),
            .ref_pin (ref_pin[g]),
            .m       (mif[g].mon)
        );
        assign mif[g].dev_tick = dev_tick;
        assign in_valid[g]     = mif[g].valid;
        assign in_edge[g]      = mif[g].edge_seen;
        assign in_phase[g]     = mif[g].phase_ok;
        assign in_per[g]       = mif[g].period;
        assign d = (in_per[g] > sel_per) ? in_per[g] - sel_per
                                         : sel_per - in_per[g];
        assign freq_ok = clk_master ? rate_match(synth_rate, in_per[g])
                                    : (d <= `ACS_PER_TOL);
        assign lock_vec[2*g +: 2] = !in_valid[g] ? ACS_LK_NONE :
            (freq_ok && in_phase[g]) ? ACS_LK_SYNC : ACS_LK_LOCK; // [RQ10]
    end

    // source scan: preferred input, then the next ones, else internal
    always_comb
    begin
        nxt_src  = ACS_SRC_INT;                                    // [RQ8]
        found    = 1'b0;
        scan_idx = pref_ff;
        if (!mode_int_ff)                                          // [RQ9]
        begin
            for (int k = 0; k < NIN; k++)
            begin
                scan_idx = 2'(pref_ff + 2'(k));
                if (!found && in_valid[scan_idx])
                begin
                    nxt_src = acs_src_t'({1'b0, scan_idx});        // [RQ7]
                    found   = 1'b1;                                // [RQ5]
                end
            end
        end
    end

    // register writes, trim commands and the refusal of slaved rates
    always_comb
    begin
        nxt_mode_int = mode_int_ff;
        nxt_pref     = pref_ff;
        nxt_m56      = m56_ff;
        nxt_rate_req = rate_req_ff;
        nxt_mask     = mask_ff;
        refused      = 1'b0;
        t            = 20'(trim_ff);
        if (reg_wr)
        begin
            if (reg_addr == `ACS_REG_CTRL)
            begin
                nxt_mode_int = reg_wdata[`ACS_CTRL_INT_BIT];
                nxt_pref     = reg_wdata[`ACS_CTRL_PREF_LSB +: 2];
                nxt_m56      = reg_wdata[`ACS_CTRL_M56_BIT];
            end
            else if (reg_addr == `ACS_REG_RATE)
            begin
                if (clk_master || rate_match(reg_wdata[17:0], sel_per))
                    nxt_rate_req = reg_wdata[17:0];
                else
                    refused = 1'b1;                                // [RQ11]
            end
            else if (reg_addr == `ACS_REG_TRIM)
            begin
                case (reg_wdata[2:0])
                    `ACS_TRIM_FINE_UP: t = t + `ACS_FINE_STEP;     // [RQ1]
                    `ACS_TRIM_FINE_DN: t = t - `ACS_FINE_STEP;     // [RQ1]
                    `ACS_TRIM_CRS_UP:  t = t + `ACS_COARSE_STEP;   // [RQ3]
                    `ACS_TRIM_CRS_DN:  t = t - `ACS_COARSE_STEP;   // [RQ3]
                    `ACS_TRIM_RESET:   t = 20'sd0;                 // [RQ3]
                    `ACS_TRIM_PULL_UP, `ACS_TRIM_PULL_DN:
                    begin
                        t = $signed({2'b00, reg_wdata[`ACS_TRIM_LARGE]
                            ? rate_req_ff / `ACS_PULL_L_DIV
                            : rate_req_ff / `ACS_PULL_S_DIV});     // [RQ2]
                        if (reg_wdata[2:0] == `ACS_TRIM_PULL_DN)
                            t = -t;
                    end
                    default: t = t;
                endcase
            end
            else if (reg_addr == `ACS_REG_IRQ_MASK)
                nxt_mask = reg_wdata[3:0];
        end
        // clamp every cycle so a later rate change cannot leave trim wide
        lim = nxt_rate_req / `ACS_LIMIT_DIV;
        if (t > $signed({2'b00, lim}))
            t = $signed({2'b00, lim});                             // [RQ1]
        else if (t < -$signed({2'b00, lim}))
            t = -$signed({2'b00, lim});                            // [RQ1]
        nxt_trim = 19'(t);
    end

    // status, channel count, interrupt and read data
    always_comb
    begin
        err_now = !clk_master && in_valid[sel_idx]
                  && !rate_match(rate_req_ff, sel_per);            // [RQ12]
        nxt_err = err_now;
        if (clk_master ? synth_rate >= `ACS_QUAD_RATE
                       : sel_per < `ACS_QUAD_PER)
            nxt_chans = `ACS_CH_QUAD;                              // [RQ13]
        else if (clk_master ? synth_rate >= `ACS_DBL_RATE
                            : sel_per < `ACS_DBL_PER)
            nxt_chans = (m56_ff ? `ACS_CH_56 : `ACS_CH_64) >> 1;   // [RQ14]
        else
            nxt_chans = m56_ff ? `ACS_CH_56 : `ACS_CH_64;
        ev = 4'h0;
        ev[`ACS_IRQ_SRC]    = nxt_src != src_ff;
        ev[`ACS_IRQ_LOCK]   = lock_vec != lock_ff;
        ev[`ACS_IRQ_ERR]    = err_now && !err_ff;
        ev[`ACS_IRQ_REFUSE] = refused;
        nxt_stat = stat_ff;
        if (reg_rd && reg_addr == `ACS_REG_IRQ_STAT)
            nxt_stat = 4'h0;
        // an event in the clearing cycle survives the read
        nxt_stat  = nxt_stat | ev;
        nxt_rdata = 32'h00000000;
        if (reg_rd)
        begin
            if (reg_addr == `ACS_REG_CTRL)
                nxt_rdata = {28'h0000000, m56_ff, pref_ff, mode_int_ff};
            else if (reg_addr == `ACS_REG_RATE)
                nxt_rdata = {14'h0000, rate_req_ff};
            else if (reg_addr == `ACS_REG_TRIM)
                nxt_rdata = {{13{trim_ff[18]}}, trim_ff};
            else if (reg_addr == `ACS_REG_STATUS)
                nxt_rdata = {19'h00000, err_ff, clk_master, src_ff,
                             lock_ff};
            else if (reg_addr == `ACS_REG_PERIOD)
                nxt_rdata = {16'h0000, sel_per};
            else if (reg_addr == `ACS_REG_INTRATE)
                nxt_rdata = {14'h0000, synth_rate};
            else if (reg_addr == `ACS_REG_CHANS)
                nxt_rdata = {25'h0000000, chans_ff};
            else if (reg_addr == `ACS_REG_IRQ_STAT)
                nxt_rdata = {28'h0000000, stat_ff};
            else if (reg_addr == `ACS_REG_IRQ_MASK)
                nxt_rdata = {28'h0000000, mask_ff};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_int_ff <= 1'b0;
            pref_ff     <= 2'h0;
            m56_ff      <= 1'b0;
            rate_req_ff <= `ACS_RATE_RST;
            trim_ff     <= 19'sd0;
            src_ff      <= ACS_SRC_INT;
            lock_ff     <= 8'h00;
            err_ff      <= 1'b0;
            chans_ff    <= `ACS_CH_64;
            stat_ff     <= 4'h0;
            mask_ff     <= 4'h0;
            rdata_ff    <= 32'h00000000;
        end
        else
        begin
            mode_int_ff <= nxt_mode_int;
            pref_ff     <= nxt_pref;
            m56_ff      <= nxt_m56;
            rate_req_ff <= nxt_rate_req;
            trim_ff     <= nxt_trim;
            src_ff      <= nxt_src;                                // [RQ6]
            lock_ff     <= lock_vec;
            err_ff      <= nxt_err;
            chans_ff    <= nxt_chans;
            stat_ff     <= nxt_stat;
            mask_ff     <= nxt_mask;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign reg_rdata   = rdata_ff;
    assign irq         = |(stat_ff & mask_ff);
    assign sample_tick = dev_tick;
    assign cur_source  = src_ff;
    assign madi_chans  = chans_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_trim_wr(logic [2:0] cmd);
        reg_wr && reg_addr == `ACS_REG_TRIM && reg_wdata[2:0] == cmd;
    endsequence

    chk_trim_bound: assert property ( // [RQ1]
        trim_ff <= $signed({1'b0, rate_req_ff / `ACS_LIMIT_DIV})
        && trim_ff >= -$signed({1'b0, rate_req_ff / `ACS_LIMIT_DIV}))
        else $error("trim beyond five percent of the base rate");
    chk_fine_step: assert property ( // [RQ1]
        s_trim_wr(`ACS_TRIM_FINE_UP) ##0 (trim_ff + 19'sd1
            <= $signed({1'b0, rate_req_ff / `ACS_LIMIT_DIV}))
        |=> trim_ff == $past(trim_ff) + 19'sd1)
        else $error("fine step did not add one hertz");
    chk_pull_small: assert property ( // [RQ2]
        s_trim_wr(`ACS_TRIM_PULL_UP) ##0 !reg_wdata[`ACS_TRIM_LARGE]
        |=> trim_ff == $signed({1'b0, $past(rate_req_ff) / 18'd1000}))
        else $error("small pull-up preset wrong");
    chk_trim_reset: assert property ( // [RQ3]
        s_trim_wr(`ACS_TRIM_RESET) |=> trim_ff == 19'sd0)
        else $error("trim reset did not return to nominal");
    chk_trim_master: assert property ( // [RQ4]
        !clk_master |-> synth_rate == rate_req_ff)
        else $error("trim applied while slaved");
    chk_follow_ext: assert property ( // [RQ5]
        !mode_int_ff && (|in_valid) |=> !clk_master)
        else $error("valid input not followed in auto mode");
    chk_lost_master: assert property ( // [RQ6] [RQ8]
        !clk_master ##1 in_valid == 4'h0 |=> clk_master)
        else $error("no fallback to internal after loss");
    chk_pref_lock: assert property ( // [RQ7]
        !mode_int_ff && in_valid[pref_ff]
        |=> src_ff == acs_src_t'({1'b0, $past(pref_ff)}))
        else $error("preferred valid input not selected");
    chk_internal_only: assert property ( // [RQ9]
        mode_int_ff |=> clk_master)
        else $error("external input used in internal mode");
    chk_refuse_rate: assert property ( // [RQ11]
        reg_wr && reg_addr == `ACS_REG_RATE && !clk_master
        && !rate_match(reg_wdata[17:0], sel_per)
        |=> $stable(rate_req_ff) && stat_ff[`ACS_IRQ_REFUSE])
        else $error("differing rate accepted while slaved");
    chk_rate_error: assert property ( // [RQ12]
        err_now |=> err_ff ##0 stat_ff[`ACS_IRQ_ERR] || $past(err_ff))
        else $error("rate mismatch not flagged");
    chk_quad_chans: assert property ( // [RQ13]
        clk_master && synth_rate >= `ACS_QUAD_RATE
        |=> madi_chans == 7'd16)
        else $error("quad rate channel count wrong");
endmodule
`default_nettype wire

// ---- hdl/acs_consts.svh ----
// offsets, field positions, reset values and counts of the clock selector
// assumes a 100 MHz core clock and byte offsets on an 8-bit register address
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_CLK_HZ        34'd100000000
`define ACS_N_IN          4

`define ACS_REG_CTRL      8'h00
`define ACS_REG_RATE      8'h04
`define ACS_REG_TRIM      8'h08
`define ACS_REG_STATUS    8'h0c
`define ACS_REG_PERIOD    8'h10
`define ACS_REG_INTRATE   8'h14
`define ACS_REG_CHANS     8'h18
`define ACS_REG_IRQ_STAT  8'h1c
`define ACS_REG_IRQ_MASK  8'h20

`define ACS_CTRL_INT_BIT  0
`define ACS_CTRL_PREF_LSB 1
`define ACS_CTRL_M56_BIT  3

`define ACS_RATE_RST      18'd48000
`define ACS_FINE_STEP     20'sd1
`define ACS_COARSE_STEP   20'sd50
`define ACS_LIMIT_DIV     18'd20
`define ACS_PULL_S_DIV    18'd1000
`define ACS_PULL_L_DIV    18'd25

`define ACS_TRIM_FINE_UP  3'h1
`define ACS_TRIM_FINE_DN  3'h2
`define ACS_TRIM_CRS_UP   3'h3
`define ACS_TRIM_CRS_DN   3'h4
`define ACS_TRIM_RESET    3'h5
`define ACS_TRIM_PULL_UP  3'h6
`define ACS_TRIM_PULL_DN  3'h7
`define ACS_TRIM_LARGE    3

`define ACS_MIN_PER       16'd4
`define ACS_MAX_PER       16'd4000
`define ACS_PER_TOL       16'd2
`define ACS_PH_WIN        8'd4
`define ACS_MATCH_MUL     34'd2

`define ACS_QUAD_RATE     18'd176400
`define ACS_DBL_RATE      18'd88200
`define ACS_QUAD_PER      16'd666
`define ACS_DBL_PER       16'd1333
`define ACS_CH_64         7'd64
`define ACS_CH_56         7'd56
`define ACS_CH_QUAD       7'd16

`define ACS_IRQ_SRC       0
`define ACS_IRQ_LOCK      1
`define ACS_IRQ_ERR       2
`define ACS_IRQ_REFUSE    3

`endif

// ---- hdl/acs_pkg.sv ----
// types shared by the clock selector modules
// assumes nothing beyond a SystemVerilog compiler
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_SRC_WORD,
        ACS_SRC_MADI,
        ACS_SRC_AES,
        ACS_SRC_SYNC,
        ACS_SRC_INT
    } acs_src_t;

    typedef enum logic [1:0] {
        ACS_LK_NONE,
        ACS_LK_LOCK,
        ACS_LK_SYNC
    } acs_lock_t;
endpackage

// ---- hdl/acs_mon_if.sv ----
// carrier between one input monitor and the selector core
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface acs_mon_if;
    logic        dev_tick;
    logic        edge_seen;
    logic [15:0] period;
    logic        valid;
    logic        phase_ok;

    modport mon (input dev_tick, output edge_seen, period, valid, phase_ok);
    modport ctl (output dev_tick, input edge_seen, period, valid, phase_ok);
endinterface
`default_nettype wire

// ---- hdl/acs_input_mon.sv ----
// period and phase monitor for one external reference clock pin
// assumes the pin is asynchronous to clk and far slower than it
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module acs_input_mon (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ref_pin,
    acs_mon_if.mon    m
);
    logic        s1_ff, s2_ff, s3_ff;
    logic [15:0] cnt_ff, nxt_cnt, prev_ff, nxt_prev;
    logic        valid_ff, nxt_valid, ph_ff, nxt_ph;
    logic [7:0]  st_ff, nxt_st, se_ff, nxt_se;
    logic        rise;
    logic [15:0] diff;

    assign rise = s2_ff & ~s3_ff;
    assign diff = (cnt_ff > prev_ff) ? cnt_ff - prev_ff : prev_ff - cnt_ff;

    always_comb
    begin
        nxt_cnt   = rise ? 16'h0001 : (&cnt_ff ? cnt_ff : cnt_ff + 16'h0001);
        nxt_prev  = prev_ff;
        nxt_valid = valid_ff;
        nxt_ph    = ph_ff;
        nxt_se    = rise ? 8'h00 : (&se_ff ? se_ff : se_ff + 8'h01);
        nxt_st    = m.dev_tick ? 8'h00 : (&st_ff ? st_ff : st_ff + 8'h01);
        if (rise)
        begin
            // two matching periods in range are needed before lock
            nxt_prev  = cnt_ff;
            nxt_valid = (cnt_ff >= `ACS_MIN_PER) && (cnt_ff <= `ACS_MAX_PER)
                        && (diff <= `ACS_PER_TOL);                 // [RQ10]
            nxt_ph    = m.dev_tick || (st_ff <= `ACS_PH_WIN);      // [RQ15]
        end
        else if (cnt_ff > `ACS_MAX_PER)
            nxt_valid = 1'b0;                                      // [RQ10]
        else if (m.dev_tick && se_ff <= `ACS_PH_WIN)
            nxt_ph = 1'b1;                                         // [RQ15]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            cnt_ff   <= 16'h0000;
            prev_ff  <= 16'h0000;
            valid_ff <= 1'b0;
            ph_ff    <= 1'b0;
            st_ff    <= 8'hff;
            se_ff    <= 8'hff;
        end
        else
        begin
            s1_ff    <= ref_pin;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            cnt_ff   <= nxt_cnt;
            prev_ff  <= nxt_prev;
            valid_ff <= nxt_valid;
            ph_ff    <= nxt_ph;
            st_ff    <= nxt_st;
            se_ff    <= nxt_se;
        end
    end

    assign m.edge_seen = rise;
    assign m.period    = prev_ff;
    assign m.valid     = valid_ff;
    assign m.phase_ok  = ph_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_timeout_drop: assert property ( // [RQ10]
        (cnt_ff > `ACS_MAX_PER) && !rise |=> !valid_ff)
        else $error("input stayed valid after its edges stopped");
endmodule
`default_nettype wire

// ---- hdl/acs_rate_synth.sv ----
// fractional tick synthesizer: one tick per sample at any rate in hertz
// assumes rate stays far below the core clock frequency
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module acs_rate_synth (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [17:0] rate,
    output logic             tick
);
    logic [26:0] acc_ff, nxt_acc;
    logic        tick_ff, nxt_tick;
    logic [33:0] sum;

    // add the rate each cycle and wrap at the core frequency: 1 Hz steps
    always_comb
    begin
        sum      = 34'(acc_ff) + 34'(rate);
        nxt_tick = sum >= `ACS_CLK_HZ;
        nxt_acc  = nxt_tick ? 27'(sum - `ACS_CLK_HZ) : 27'(sum);   // [RQ1]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_ff  <= 27'h0000000;
            tick_ff <= 1'b0;
        end
        else
        begin
            acc_ff  <= nxt_acc;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_tick_wrap: assert property ( // [RQ1]
        tick_ff |-> (acc_ff < 27'($past(rate))))
        else $error("accumulator did not wrap on a tick");
endmodule
`default_nettype wire

// ---- verification/acs_ref_model.sv ----
// external gear: four reference clocks with an 80 ns period
// assumes the bench enables each source; a disabled one idles low
`timescale 1ns/1ps
`default_nettype none
module acs_ref_model (
    input  wire logic [3:0] en,
    output logic      [3:0] ref_pin
);
    logic ph = 1'b0;
    // odd offset keeps pin edges clear of the core clock edges
    initial
    begin
        #3;
        forever #40 ph = ~ph;
    end
    assign ref_pin = en & {4{ph}};
endmodule
`default_nettype wire

// ---- verification/tb_acs_clk_sel.sv ----
// self-checking bench of the clock selector over its register port
// assumes the reference model drives the four reference pins
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module tb_acs_clk_sel;
    import acs_pkg::*;
    logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [3:0]  en = 4'h0, ref_pin;
    logic        irq, sample_tick, clk_master;
    acs_src_t    cur_source;
    logic [6:0]  madi_chans;
    int          errors = 0, n_checks = 0, cyc = 0;
    logic [3:0]  tc [11] = '{4'h1, 4'h3, 4'h2, 4'h4, 4'h1, 4'h5,
                             4'h6, 4'he, 4'h7, 4'hf, 4'h5};
    logic [31:0] te [11] = '{32'd1, 32'd51, 32'd50, 32'd0, 32'd1,
                             32'd0, 32'd48, 32'd1920, -32'sd48,
                             -32'sd1920, 32'd0};

    acs_ref_model i_ref (.en(en), .ref_pin(ref_pin));
    acs_clk_sel i_dut (.clk(clk), .rst(rst), .ref_pin(ref_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .sample_tick(sample_tick), .clk_master(clk_master),
        .cur_source(cur_source), .madi_chans(madi_chans));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        // settle before any caller samples an output after the write
        @(negedge clk);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk(nm, reg_rdata, e);
    endtask

    task automatic wait_src(input acs_src_t s);
        int k;
        for (k = 0; k < 6000 && cur_source !== s; k++)
            @(negedge clk);
        chk("source", {29'h0, cur_source}, {29'h0, s});
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            conclude();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("source", {29'h0, cur_source}, {29'h0, ACS_SRC_INT});
        chk("master", {31'h0, clk_master}, 32'h1);
        rchk("rate", `ACS_REG_RATE, 32'd48000);
        rchk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 11; i++)
        begin
            wr(`ACS_REG_TRIM, {28'h0, tc[i]});
            rchk("trim", `ACS_REG_TRIM, te[i]);
        end
        // push past the 5% limit: 48000/20 = 2400
        for (int i = 0; i < 50; i++)
            wr(`ACS_REG_TRIM, 32'h3);
        rchk("trim", `ACS_REG_TRIM, 32'd2400);
        rchk("intrate", `ACS_REG_INTRATE, 32'd50400);
        wr(`ACS_REG_RATE, 32'd96000);
        rchk("chans", `ACS_REG_CHANS, 32'd32);
        wr(`ACS_REG_CTRL, 32'h8);
        rchk("chans", `ACS_REG_CHANS, 32'd28);
        wr(`ACS_REG_RATE, 32'd192000);
        rchk("chans", `ACS_REG_CHANS, 32'd16);
        wr(`ACS_REG_CTRL, 32'h0);
        wr(`ACS_REG_RATE, 32'd48000);
        rchk("chans", `ACS_REG_CHANS, 32'd64);
        en <= 4'h3;
        wait_src(ACS_SRC_WORD);
        chk("master", {31'h0, clk_master}, 32'h0);
        // one device tick per input period once slaved; phase settles too
        v = 32'h0;
        repeat (80)
        begin
            @(negedge clk);
            v = v + {31'h0, sample_tick};
        end
        chk("ticks", v, 32'd10);
        chk("chans", {25'h0, madi_chans}, 32'd16);
        rchk("status", `ACS_REG_STATUS, 32'h100a);
        rchk("period", `ACS_REG_PERIOD, 32'd8);
        rchk("intrate", `ACS_REG_INTRATE, 32'd48000);
        rchk("irq_stat", `ACS_REG_IRQ_STAT, 32'h7);
        wr(`ACS_REG_IRQ_MASK, 32'h8);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`ACS_REG_RATE, 32'd44100);
        rchk("rate", `ACS_REG_RATE, 32'd48000);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk("irq_stat", `ACS_REG_IRQ_STAT, 32'h8);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`ACS_REG_CTRL, 32'h2);
        wait_src(ACS_SRC_MADI);
        wr(`ACS_REG_CTRL, 32'h3);
        wait_src(ACS_SRC_INT);
        chk("master", {31'h0, clk_master}, 32'h1);
        wr(`ACS_REG_CTRL, 32'h0);
        wait_src(ACS_SRC_WORD);
        en <= 4'h0;
        wait_src(ACS_SRC_INT);
        rchk("status", `ACS_REG_STATUS, 32'hc00);
        conclude();
    end
endmodule
`default_nettype wire
